// [src/gpab_pkg.sv]
/*
  constants shared by the two-port general purpose i/o block: register byte
  offsets, reset values, field positions and the analog pin selection table.
  assumes a 32-bit avalon-mm slave with one register per aligned word.
*/
package gpab_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int GPAB_ADDR_W = 6;
  localparam int GPAB_PA_W = 6;
  localparam int GPAB_PB_W = 8;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [5:0] GPAB_OFS_PA_LEVELS = 6'h00;
  localparam logic [5:0] GPAB_OFS_PA_LATCH = 6'h04;
  localparam logic [5:0] GPAB_OFS_PA_DIR = 6'h08;
  localparam logic [5:0] GPAB_OFS_ANALOG_CFG = 6'h0C;
  localparam logic [5:0] GPAB_OFS_PB_LEVELS = 6'h10;
  localparam logic [5:0] GPAB_OFS_PB_LATCH = 6'h14;
  localparam logic [5:0] GPAB_OFS_PB_DIR = 6'h18;
  localparam logic [5:0] GPAB_OFS_CHANGE_CTRL = 6'h1C;
  localparam logic [5:0] GPAB_OFS_PIN_ROUTE = 6'h20;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [5:0] GPAB_PA_DIR_RST = 6'h3F;
  localparam logic [7:0] GPAB_PB_DIR_RST = 8'hFF;
  localparam logic [7:0] GPAB_ANALOG_CFG_RST = 8'h00;
  localparam logic [5:0] GPAB_PA_LATCH_RST = 6'h00;
  localparam logic [7:0] GPAB_PB_LATCH_RST = 8'h00;
  localparam logic GPAB_PULLUP_DIS_N_RST = 1'b1;
  localparam logic GPAB_PRIORITY_RST = 1'b1;
  localparam logic GPAB_ROUTE_RST = 1'b1;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam logic [7:0] GPAB_ANALOG_CFG_MASK = 8'hCF;
  localparam int GPAB_CTRL_FLAG_BIT = 0;
  localparam int GPAB_CTRL_ENABLE_BIT = 1;
  localparam int GPAB_CTRL_PRIORITY_BIT = 2;
  localparam int GPAB_CTRL_PULLUP_BIT = 3;
  localparam int GPAB_ROUTE_BIT = 0;
  localparam int GPAB_OD_PIN = 4;
  localparam int GPAB_ALT_PIN = 3;
  localparam int GPAB_CHG_LO = 4;
  localparam logic [5:0] GPAB_OD_MASK = 6'h10;

  // ------------------------------------------------------------
  // analog mask per select code, bit set = pin is analog
  // ------------------------------------------------------------
  localparam logic [5:0] GPAB_ANALOG_MAP [16] = '{
    6'h2F, 6'h2F, 6'h2F, 6'h2F, 6'h0F, 6'h0F, 6'h00, 6'h00,
    6'h2F, 6'h2F, 6'h2F, 6'h2F, 6'h0F, 6'h07, 6'h03, 6'h01
  };

endpackage

// [src/gpab_top.sv]
/*
  two-port general purpose i/o block: port a (6 pins, one open drain, analog
  sharing) and port b (8 pins, weak pull-ups, change detection on pins 7..4).
  assumes pins come from outside the clock domain and a synchronous avalon-mm
  master on clk_in; the peripheral for the alternate pin is on clk_in too.
*/
// Implementation choices: the placing of the registers and register access over Avalon-MM.
//
// Contract
// - port a six pins, direction one tri-states
// - port b eight pins, same direction convention
// - reset sets all direction bits to input
// - pin register reads pins, writes latch
// - latch register reads back latched value
// - port a pin four open drain, timer clock
// - analog pins start analog, read zero
// - four-bit field selects analog or digital
// - one active-low bit enables all pull-ups
// - output pins never get a pull-up
// - reset disables all port b pull-ups
// - only input pins 7..4 are compared
// - mismatches against snapshot set change flag
// - persisting mismatch keeps setting the flag
// - port b access refreshes snapshot, except moves
// - change event can wake from sleep
// - route bit zero puts unit two on pin3
// - enabled peripheral takes over its pin
// - enable bit gates change event to interrupt
// - priority bit selects high or low
`timescale 1ns/1ps
`default_nettype none

module gpab_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [gpab_pkg::GPAB_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic mem_move_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [gpab_pkg::GPAB_PA_W-1:0] pa_pin_in,
  output logic [gpab_pkg::GPAB_PA_W-1:0] pa_pin_out,
  output logic [gpab_pkg::GPAB_PA_W-1:0] pa_pin_oe_out,
  input wire logic [gpab_pkg::GPAB_PB_W-1:0] pb_pin_in,
  output logic [gpab_pkg::GPAB_PB_W-1:0] pb_pin_out,
  output logic [gpab_pkg::GPAB_PB_W-1:0] pb_pin_oe_out,
  output logic [gpab_pkg::GPAB_PB_W-1:0] pb_pullup_en_out,
  output logic timer_clk_out,
  input wire logic unit2_enable_in,
  input wire logic unit2_drive_in,
  input wire logic unit2_oe_in,
  output logic unit2_pin_out,
  output logic change_irq_high_out,
  output logic change_irq_low_out,
  output logic wake_out
);
  import gpab_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic ack;
  logic [5:0] pa_meta, pa_sync;
  logic [7:0] pb_meta, pb_sync;
  logic [5:0] port_a_output_latch;
  logic [5:0] port_a_direction;
  logic [7:0] analog_pin_config;
  logic [7:0] port_b_output_latch;
  logic [7:0] port_b_direction;
  logic [3:0] snapshot;
  logic port_change_flag;
  logic port_change_enable;
  logic port_change_priority;
  logic pullup_disable_n;
  logic capture_unit2_pin_route;

  logic accept, wr_acc, rd_acc;
  logic [7:0] wbyte;
  logic [5:0] analog_mask;
  logic [3:0] compare_bits;
  logic mismatch;
  logic pb_touch;
  logic alt_taken;
  logic [7:0] next_rdata;

  assign wbyte = avs_writedata_in[7:0];
  assign accept = (avs_read_in | avs_write_in) & ~ack;
  assign wr_acc = accept & avs_write_in & avs_byteenable_in[0];
  assign rd_acc = accept & avs_read_in;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;

  // ------------------------------------------------------------
  // bus handshake: one wait cycle per request
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= accept;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pa_meta <= 6'h00;
      pa_sync <= 6'h00;
      pb_meta <= 8'h00;
      pb_sync <= 8'h00;
    end else begin
      pa_meta <= pa_pin_in;
      pa_sync <= pa_meta;
      pb_meta <= pb_pin_in;
      pb_sync <= pb_meta;
    end
  end

  // ------------------------------------------------------------
  // port a registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port_a_output_latch <= GPAB_PA_LATCH_RST;
      port_a_direction <= GPAB_PA_DIR_RST;
      analog_pin_config <= GPAB_ANALOG_CFG_RST;
    end else if (wr_acc) begin
      if (avs_address_in == GPAB_OFS_PA_LEVELS || avs_address_in == GPAB_OFS_PA_LATCH) begin
        port_a_output_latch <= wbyte[5:0];
      end else if (avs_address_in == GPAB_OFS_PA_DIR) begin
        port_a_direction <= wbyte[5:0];
      end else if (avs_address_in == GPAB_OFS_ANALOG_CFG) begin
        analog_pin_config <= wbyte & GPAB_ANALOG_CFG_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // port b registers and change control
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port_b_output_latch <= GPAB_PB_LATCH_RST;
      port_b_direction <= GPAB_PB_DIR_RST;
      port_change_enable <= 1'b0;
      port_change_priority <= GPAB_PRIORITY_RST;
      pullup_disable_n <= GPAB_PULLUP_DIS_N_RST;
      capture_unit2_pin_route <= GPAB_ROUTE_RST;
    end else if (wr_acc) begin
      if (avs_address_in == GPAB_OFS_PB_LEVELS || avs_address_in == GPAB_OFS_PB_LATCH) begin
        port_b_output_latch <= wbyte;
      end else if (avs_address_in == GPAB_OFS_PB_DIR) begin
        port_b_direction <= wbyte;
      end else if (avs_address_in == GPAB_OFS_CHANGE_CTRL) begin
        port_change_enable <= wbyte[GPAB_CTRL_ENABLE_BIT];
        port_change_priority <= wbyte[GPAB_CTRL_PRIORITY_BIT];
        pullup_disable_n <= wbyte[GPAB_CTRL_PULLUP_BIT];
      end else if (avs_address_in == GPAB_OFS_PIN_ROUTE) begin
        capture_unit2_pin_route <= wbyte[GPAB_ROUTE_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // change detection
  // ------------------------------------------------------------
  assign compare_bits = (pb_sync[7:GPAB_CHG_LO] ^ snapshot) & port_b_direction[7:GPAB_CHG_LO];
  assign mismatch = |compare_bits;
  assign pb_touch = accept & ~mem_move_in & (avs_address_in == GPAB_OFS_PB_LEVELS) &
                    (avs_read_in | avs_byteenable_in[0]);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      snapshot <= 4'h0;
    end else if (pb_touch) begin
      snapshot <= pb_sync[7:GPAB_CHG_LO];
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      port_change_flag <= 1'b0;
    end else if (mismatch) begin
      port_change_flag <= 1'b1;
    end else if (wr_acc && avs_address_in == GPAB_OFS_CHANGE_CTRL) begin
      port_change_flag <= wbyte[GPAB_CTRL_FLAG_BIT];
    end
  end

  assign change_irq_high_out = port_change_flag & port_change_enable & port_change_priority;
  assign change_irq_low_out = port_change_flag & port_change_enable & ~port_change_priority;
  assign wake_out = port_change_flag & port_change_enable;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  assign analog_mask = GPAB_ANALOG_MAP[analog_pin_config[3:0]];

  always_comb begin
    next_rdata = 8'h00;
    if (avs_address_in == GPAB_OFS_PA_LEVELS) begin
      next_rdata = {2'b00, pa_sync & ~analog_mask};
    end else if (avs_address_in == GPAB_OFS_PA_LATCH) begin
      next_rdata = {2'b00, port_a_output_latch};
    end else if (avs_address_in == GPAB_OFS_PA_DIR) begin
      next_rdata = {2'b00, port_a_direction};
    end else if (avs_address_in == GPAB_OFS_ANALOG_CFG) begin
      next_rdata = analog_pin_config;
    end else if (avs_address_in == GPAB_OFS_PB_LEVELS) begin
      next_rdata = pb_sync;
    end else if (avs_address_in == GPAB_OFS_PB_LATCH) begin
      next_rdata = port_b_output_latch;
    end else if (avs_address_in == GPAB_OFS_PB_DIR) begin
      next_rdata = port_b_direction;
    end else if (avs_address_in == GPAB_OFS_CHANGE_CTRL) begin
      next_rdata = {4'h0, pullup_disable_n, port_change_priority, port_change_enable, port_change_flag};
    end else if (avs_address_in == GPAB_OFS_PIN_ROUTE) begin
      next_rdata = {7'h00, capture_unit2_pin_route};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_acc) begin
      avs_readdata_out <= {24'h00_0000, next_rdata};
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  assign alt_taken = ~capture_unit2_pin_route & unit2_enable_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pa_pin_out <= 6'h00;
      pa_pin_oe_out <= 6'h00;
      pb_pin_out <= 8'h00;
      pb_pin_oe_out <= 8'h00;
    end else begin
      pa_pin_out <= port_a_output_latch & ~GPAB_OD_MASK;
      pa_pin_oe_out <= ~port_a_direction & ~(GPAB_OD_MASK & port_a_output_latch);
      pb_pin_out <= port_b_output_latch;
      pb_pin_oe_out <= ~port_b_direction;
      if (alt_taken) begin
        pb_pin_out[GPAB_ALT_PIN] <= unit2_drive_in;
        pb_pin_oe_out[GPAB_ALT_PIN] <= unit2_oe_in;
      end
    end
  end

  assign pb_pullup_en_out = {8{~pullup_disable_n}} & port_b_direction;
  assign timer_clk_out = pa_sync[GPAB_OD_PIN];
  assign unit2_pin_out = pb_sync[GPAB_ALT_PIN];

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_pb_access;
    pb_touch;
  endsequence

  sequence s_pa_levels_read;
    rd_acc && avs_address_in == GPAB_OFS_PA_LEVELS;
  endsequence

  AST_DIR_RESET: assert property ($fell(sys_rst_in) |->
    port_a_direction == GPAB_PA_DIR_RST && port_b_direction == GPAB_PB_DIR_RST)
    else $error("direction not all input after reset");

  AST_PA_DRIVE: assert property ((pa_pin_oe_out & ~GPAB_OD_MASK) ==
    ($past(~port_a_direction) & ~GPAB_OD_MASK))
    else $error("port a enable does not follow direction");

  AST_OPEN_DRAIN: assert property (pa_pin_oe_out[GPAB_OD_PIN] |-> !pa_pin_out[GPAB_OD_PIN])
    else $error("open drain pin drove high");

  AST_PB_DRIVE: assert property (!$past(alt_taken) |-> pb_pin_oe_out == $past(~port_b_direction) &&
    pb_pin_out == $past(port_b_output_latch))
    else $error("port b drive mismatch");

  AST_PULLUP_OUTPUT: assert property ((pb_pullup_en_out & ~port_b_direction) == 8'h00)
    else $error("pull-up on output pin");

  AST_PULLUP_RESET: assert property ($fell(sys_rst_in) |-> pb_pullup_en_out == 8'h00)
    else $error("pull-ups on after reset");

  AST_ANALOG_ZERO: assert property (s_pa_levels_read |=>
    (avs_readdata_out[5:0] & $past(analog_mask)) == 6'h00)
    else $error("analog pin read non-zero");

  AST_LATCH_WRITE: assert property (wr_acc && avs_address_in == GPAB_OFS_PA_LEVELS |=>
    port_a_output_latch == $past(wbyte[5:0]))
    else $error("pin register write missed the latch");

  AST_FLAG_PERSIST: assert property (mismatch |=> port_change_flag [*1])
    else $error("flag not held while mismatch");

  AST_SNAPSHOT: assert property (s_pb_access |=> snapshot == $past(pb_sync[7:GPAB_CHG_LO]))
    else $error("snapshot not refreshed");

  AST_IRQ_GATE: assert property (port_change_flag && !port_change_enable |->
    !change_irq_high_out && !change_irq_low_out)
    else $error("interrupt raised while disabled");

  AST_BUS_ANSWER: assert property (accept |=> !avs_waitrequest_out ##1 !ack)
    else $error("bus answer not after one wait cycle");

  sequence s_ctrl_write;
    wr_acc && avs_address_in == GPAB_OFS_CHANGE_CTRL;
  endsequence

  sequence s_move_access;
    accept && mem_move_in && avs_address_in == GPAB_OFS_PB_LEVELS;
  endsequence

  AST_OD_ENABLE: assert property (pa_pin_oe_out[GPAB_OD_PIN] ==
    $past(!port_a_direction[GPAB_OD_PIN] && !port_a_output_latch[GPAB_OD_PIN]))
    else $error("open drain pin enable wrong");

  AST_PA_OUT: assert property (pa_pin_out == ($past(port_a_output_latch) & ~GPAB_OD_MASK))
    else $error("port a output does not follow latch");

  AST_PA_SYNC: assert property (!$past(sys_rst_in, 2) |-> pa_sync == $past(pa_pin_in, 2))
    else $error("port a pins not synchronised in two stages");

  AST_PB_SYNC: assert property (!$past(sys_rst_in, 2) |-> pb_sync == $past(pb_pin_in, 2))
    else $error("port b pins not synchronised in two stages");

  AST_TIMER_CLK: assert property (!$past(sys_rst_in, 2) |->
    timer_clk_out == $past(pa_pin_in[GPAB_OD_PIN], 2))
    else $error("timer clock does not follow pin four");

  AST_PULLUP_ENABLE: assert property (!pullup_disable_n |-> pb_pullup_en_out == port_b_direction)
    else $error("pull-ups do not follow input pins");

  AST_FLAG_CLEAR: assert property (s_ctrl_write ##0 (!wbyte[GPAB_CTRL_FLAG_BIT] && !mismatch) |=>
    !port_change_flag)
    else $error("flag not cleared by software");

  AST_FLAG_QUIET: assert property (!port_change_flag && !wr_acc &&
    ((pb_sync[7:GPAB_CHG_LO] ^ snapshot) & port_b_direction[7:GPAB_CHG_LO]) == 4'h0 |=> !port_change_flag)
    else $error("change flag set without an input mismatch");

  AST_IRQ_HIGH: assert property (port_change_flag && port_change_enable && port_change_priority |->
    change_irq_high_out && !change_irq_low_out)
    else $error("high priority request wrong");

  AST_IRQ_LOW: assert property (port_change_flag && port_change_enable && !port_change_priority |->
    change_irq_low_out && !change_irq_high_out)
    else $error("low priority request wrong");

  AST_WAKE: assert property (wake_out == (port_change_flag && port_change_enable))
    else $error("wake does not follow enabled flag");

  AST_ALT_PIN: assert property ($past(alt_taken) |-> pb_pin_out[GPAB_ALT_PIN] == $past(unit2_drive_in) &&
    pb_pin_oe_out[GPAB_ALT_PIN] == $past(unit2_oe_in))
    else $error("unit two did not take pin three");

  AST_MOVE_KEEPS: assert property (s_move_access |=> $stable(snapshot))
    else $error("memory move refreshed the snapshot");

  AST_PB_LATCH_WRITE: assert property (wr_acc && avs_address_in == GPAB_OFS_PB_LEVELS |=>
    port_b_output_latch == $past(wbyte))
    else $error("port b pin register write missed the latch");

  AST_UNMAPPED_READ: assert property (rd_acc && avs_address_in > GPAB_OFS_PIN_ROUTE |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");

endmodule

`default_nettype wire

// [testbench/gpab_board.sv]
/*
  board model for the two gpio ports: resolves every pin from the block's
  drivers, the port b pull-ups and the board's own sources.
  assumes one clock shared with the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module gpab_board (
  input wire logic clk_in,
  input wire logic [5:0] pa_out_in,
  input wire logic [5:0] pa_oe_in,
  input wire logic [7:0] pb_out_in,
  input wire logic [7:0] pb_oe_in,
  input wire logic [7:0] pb_pu_in,
  input wire logic [5:0] pa_src_in,
  input wire logic [7:0] pb_src_in,
  input wire logic [7:0] pb_src_en_in,
  output logic [5:0] pa_lvl_out,
  output logic [7:0] pb_lvl_out
);
  logic [7:0] flt = 8'h5A;
  // an undriven, unpulled line wanders every cycle
  always @(posedge clk_in) begin
    flt <= ~flt;
  end
  always_comb begin
    pa_lvl_out = (pa_oe_in & pa_out_in) | (~pa_oe_in & pa_src_in);
    pb_lvl_out = (pb_oe_in & pb_out_in) |
      (~pb_oe_in & ((pb_src_en_in & pb_src_in) | (~pb_src_en_in & (pb_pu_in | flt))));
  end
endmodule
`default_nettype wire

// [testbench/gpio_ports_a_b_tb.sv]
/*
  self-checking bench for gpab_top: avalon master tasks, board model and
  random pin values. assumes the slave ends every access by dropping waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_a_b_tb;
  import gpab_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in, rd, wr, mv, u2en, u2dr, u2oe, wq, u2pin, tclk, irqh, irql, wake;
  logic [5:0] addr, pa_src, pa_lvl, pa_out, pa_oe;
  logic [7:0] pb_src, pb_se, pb_lvl, pb_out, pb_oe, pb_pu, l, d, e, s;
  logic [31:0] wdata, rdata, q, v;
  logic [31:0] seed = 32'h006B;
  logic [3:0] be;
  int fails = 0;
  int cmp_count = 0;

  gpab_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .mem_move_in(mv),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wq), .pa_pin_in(pa_lvl), .pa_pin_out(pa_out),
    .pa_pin_oe_out(pa_oe), .pb_pin_in(pb_lvl), .pb_pin_out(pb_out), .pb_pin_oe_out(pb_oe),
    .pb_pullup_en_out(pb_pu), .timer_clk_out(tclk), .unit2_enable_in(u2en), .unit2_drive_in(u2dr),
    .unit2_oe_in(u2oe), .unit2_pin_out(u2pin), .change_irq_high_out(irqh),
    .change_irq_low_out(irql), .wake_out(wake));

  gpab_board board (.clk_in(clk_in), .pa_out_in(pa_out), .pa_oe_in(pa_oe), .pb_out_in(pb_out),
    .pb_oe_in(pb_oe), .pb_pu_in(pb_pu), .pa_src_in(pa_src), .pb_src_in(pb_src),
    .pb_src_en_in(pb_se), .pa_lvl_out(pa_lvl), .pb_lvl_out(pb_lvl));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] pb_exp(input logic [7:0] dd, ll, ee, ss);
    return (~dd & ll) | (dd & ((ee & ss) | ~ee));
  endfunction

  // pin four only ever pulls low
  function automatic logic [5:0] pa_oe_exp(input logic [5:0] dd, ll);
    return ~dd & ~(ll & GPAB_OD_MASK);
  endfunction

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request stands until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] dt, input logic m);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, dt};
    mv <= m;
    rd <= ~w;
    wr <= w;
    @(posedge clk_in);
    while (wq !== 1'b0) begin
      n++;
      if (n > 50) begin
        fails++;
        tally_and_finish();
      end
      @(posedge clk_in);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    mv <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wrr(input logic [5:0] a, input logic [7:0] dt);
    bus(1'b1, a, dt, 1'b0);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(q, {24'h0, exp});
  endtask

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    sys_rst_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    mv = 1'b0;
    be = 4'h1;
    addr = 6'h00;
    wdata = 32'h0;
    u2en = 1'b0;
    u2dr = 1'b0;
    u2oe = 1'b0;
    pa_src = 6'h3F;
    pb_src = 8'h00;
    pb_se = 8'hFF;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk({10'h000, pa_oe, pb_oe, pb_pu}, 32'h0);
    rdc(GPAB_OFS_PA_DIR, 8'h3F);
    rdc(GPAB_OFS_PB_DIR, 8'hFF);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h0C);
    rdc(GPAB_OFS_PA_LEVELS, 8'h10);
    rdc(6'h24, 8'h00);
    wrr(GPAB_OFS_ANALOG_CFG, 8'hFF);
    be <= 4'h0;
    wrr(GPAB_OFS_ANALOG_CFG, 8'h00);
    be <= 4'h1;
    rdc(GPAB_OFS_ANALOG_CFG, 8'hCF);
    for (int c = 0; c < 16; c++) begin
      v = xs();
      pa_src <= v[5:0];
      wrr(GPAB_OFS_ANALOG_CFG, 8'(c));
      rdc(GPAB_OFS_PA_LEVELS, {2'b00, v[5:0] & ~GPAB_ANALOG_MAP[c]});
    end
    wrr(GPAB_OFS_ANALOG_CFG, 8'h06);
    for (int i = 0; i < 6; i++) begin
      v = xs();
      l = {2'b00, v[5:0]};
      d = {2'b00, v[13:8]};
      s = {2'b00, v[21:16]};
      pa_src <= s[5:0];
      wrr(i[0] ? GPAB_OFS_PA_LEVELS : GPAB_OFS_PA_LATCH, l);
      wrr(GPAB_OFS_PA_DIR, d);
      e = {2'b00, pa_oe_exp(d[5:0], l[5:0])};
      chk({26'h0, pa_oe}, {24'h0, e});
      chk({26'h0, pa_out & ~d[5:0]}, {26'h0, l[5:0] & ~d[5:0] & ~GPAB_OD_MASK});
      rdc(GPAB_OFS_PA_LATCH, l);
      rdc(GPAB_OFS_PA_LEVELS, (e & l & 8'h2F) | (~e & s));
      chk({31'h0, tclk}, {31'h0, ~e[4] & s[4]});
    end
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = xs();
      l = v[7:0];
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : v[15:8];
      e = v[23:16];
      s = v[31:24];
      pb_src <= s;
      pb_se <= e;
      wrr(GPAB_OFS_PB_LATCH, l);
      wrr(GPAB_OFS_PB_DIR, d);
      chk({24'h0, pb_oe}, {24'h0, ~d});
      chk({24'h0, pb_pu}, {24'h0, d});
      rdc(GPAB_OFS_PB_LATCH, l);
      rdc(GPAB_OFS_PB_LEVELS, pb_exp(d, l, e, s));
    end
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h08);
    chk({24'h0, pb_pu}, 32'h0);
    wrr(GPAB_OFS_PB_DIR, 8'h1F);
    pb_se <= 8'hFF;
    pb_src <= 8'h00;
    repeat (3) @(posedge clk_in);
    bus(1'b0, GPAB_OFS_PB_LEVELS, 8'h00, 1'b0);
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h06);
    wrr(GPAB_OFS_PB_LATCH, ~l);
    pb_src <= 8'h0F;
    repeat (3) @(posedge clk_in);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h06);
    pb_src <= 8'h10;
    repeat (3) @(posedge clk_in);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h07);
    chk({29'h0, irqh, irql, wake}, 32'h5);
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h06);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h07);
    bus(1'b0, GPAB_OFS_PB_LEVELS, 8'h00, 1'b1);
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h06);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h07);
    wrr(GPAB_OFS_PB_LEVELS, 8'h00);
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h02);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h02);
    pb_src <= 8'h00;
    repeat (3) @(posedge clk_in);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h03);
    chk({29'h0, irqh, irql, wake}, 32'h3);
    wrr(GPAB_OFS_CHANGE_CTRL, 8'h00);
    rdc(GPAB_OFS_CHANGE_CTRL, 8'h01);
    chk({29'h0, irqh, irql, wake}, 32'h0);
    u2en <= 1'b1;
    u2oe <= 1'b1;
    u2dr <= 1'b1;
    wrr(GPAB_OFS_PB_DIR, 8'hFF);
    wrr(GPAB_OFS_PIN_ROUTE, 8'h00);
    repeat (3) @(posedge clk_in);
    chk({29'h0, pb_oe[3], pb_out[3], u2pin}, 32'h7);
    wrr(GPAB_OFS_PIN_ROUTE, 8'h01);
    chk({31'h0, pb_oe[3]}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
